// ==== pkg/dpll_sel_defines.svh ====
// Register map, field positions and reset values of the DPLL mode and
// reference selection block. Included by its bare name; defines only.
`ifndef DPLL_SEL_DEFINES_SVH
`define DPLL_SEL_DEFINES_SVH

// ==========================================================
// Register offsets and reset values
`define MODE_SEL_ADDR 8'h33
`define FAIL_MASK_ADDR 8'h34
`define MODE_SEL_RESET 8'h03
`define FAIL_MASK_RESET 8'h87

// ==========================================================
// Field positions
`define MODE_MSB 1
`define MODE_LSB 0
`define FBCOMP_BIT 5
`define REFSEL_MSB 7
`define REFSEL_LSB 6
`define HOLD_MSK_MSB 3
`define HOLD_MSK_LSB 0
`define SW_MSK_MSB 7
`define SW_MSK_LSB 4

// Rank code that takes a reference out of automatic selection
`define RANK_DISABLED 3'h7

`endif

// ==== pkg/dpll_sel_pkg.sv ====
// Types and shared helpers of the DPLL mode and reference selection block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package dpll_sel_pkg;

	// ==========================================================
	// Operating mode codes as held in the mode field
	typedef enum logic [1:0] {
		MODE_FREERUN = 2'h0,
		MODE_HOLDOVER = 2'h1,
		MODE_FORCED = 2'h2,
		MODE_AUTO = 2'h3
	} op_mode_t;

	// ==========================================================
	// Loop state, Gray coded along freerun, locked, holdover
	typedef enum logic [1:0] {
		ST_FREERUN = 2'h0,
		ST_LOCKED = 2'h1,
		ST_HOLDOVER = 2'h3
	} loop_state_t;

	// Any failure type whose mask bit is one
	function automatic logic masked_fail(input logic [3:0] fails, input logic [3:0] mask);
		masked_fail = |(fails & mask);
	endfunction : masked_fail

endpackage : dpll_sel_pkg
`default_nettype wire

// ==== verilog/ref_chooser.sv ====
// Automatic-mode reference chooser between two references.
// Assumes per-reference failure flags already gated by the masks.
`timescale 1ns/1ps
`default_nettype none
`include "dpll_sel_defines.svh"

module ref_chooser (
	input wire logic sel_cur,
	input wire logic [2:0] rank0,
	input wire logic [2:0] rank1,
	input wire logic [1:0] hold_fail,
	input wire logic [1:0] switch_fail,
	output logic [1:0] usable,
	output logic sel_next,
	output logic hold_next
);

	logic [2:0] rank_cur;
	logic [2:0] rank_oth;
	logic oth;
	logic cur_gone;

	// ==========================================================
	// Decision
	// Usable means no unmasked failure of either kind and not disabled
	always_comb begin
		usable[0] = !hold_fail[0] && !switch_fail[0] && (rank0 != `RANK_DISABLED);
		usable[1] = !hold_fail[1] && !switch_fail[1] && (rank1 != `RANK_DISABLED);
		oth = !sel_cur;
		rank_cur = sel_cur ? rank1 : rank0;
		rank_oth = sel_cur ? rank0 : rank1;
		// Disabled current reference counts as a switch-worthy loss
		cur_gone = switch_fail[sel_cur] || (rank_cur == `RANK_DISABLED);
		sel_next = sel_cur;
		hold_next = 1'b0;
		if (usable[sel_cur]) begin
			// Strictly better rank only: equal ranks stay put
			if (usable[oth] && (rank_oth < rank_cur)) begin
				sel_next = oth;
			end
		end else if (cur_gone && usable[oth]) begin
			sel_next = oth;
		end else begin
			// Masked-only failure keeps lock; unmasked holdover failure holds
			hold_next = hold_fail[sel_cur] || (rank_cur == `RANK_DISABLED);
		end
	end

endmodule : ref_chooser
`default_nettype wire

// ==== verilog/dpll_mode_select.sv ====
// DPLL operating mode and input reference selection with its two
// control registers. Assumes failure monitor flags and ranks are levels
// synchronous to clk_sys, and a simple byte register port.
`timescale 1ns/1ps
`default_nettype none
`include "dpll_sel_defines.svh"

module dpll_mode_select #(
	parameter int PHASE_W = 16
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] signal_loss_monitor,
	input wire logic [1:0] cycle_period_monitor,
	input wire logic [1:0] frequency_range_monitor,
	input wire logic [1:0] guard_soak_timer,
	input wire logic [2:0] reference_zero_rank,
	input wire logic [2:0] reference_one_rank,
	input wire logic [PHASE_W-1:0] ext_feedback_phase,
	output logic selected_ref,
	output logic [1:0] pll_state,
	output logic oscillator_only,
	output logic feedback_compensation_on,
	output logic [PHASE_W-1:0] feedback_phase_comp
);

	// ==========================================================
	// Register file
	dpll_sel_pkg::op_mode_t mode_r, mode_nxt;
	logic fbcomp_r, fbcomp_nxt;
	logic [1:0] refsel_r, refsel_nxt;
	logic [7:0] mask_r, mask_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic [7:0] mode_rd;
	// Selection is read back through the status field, so it is declared here
	logic sel_r, sel_nxt;
	// Reset image of the mode register, sliced per field below
	localparam logic [7:0] MODE_RESET_VAL = `MODE_SEL_RESET;

	// Writes land at the documented offsets; reserved bits are not stored
	always_comb begin
		mode_nxt = mode_r;
		fbcomp_nxt = fbcomp_r;
		refsel_nxt = refsel_r;
		mask_nxt = mask_r;
		if (reg_wr && (reg_addr == `MODE_SEL_ADDR)) begin
			mode_nxt = dpll_sel_pkg::op_mode_t'(reg_wdata[`MODE_MSB:`MODE_LSB]);
			fbcomp_nxt = reg_wdata[`FBCOMP_BIT];
			// Stored in every mode so a later switch to forced sees it
			refsel_nxt = reg_wdata[`REFSEL_MSB:`REFSEL_LSB];
		end
		if (reg_wr && (reg_addr == `FAIL_MASK_ADDR)) begin
			mask_nxt = reg_wdata;
		end
	end

	// Read view: status replaces the reference field in automatic mode
	always_comb begin
		mode_rd = 8'h00;
		mode_rd[`MODE_MSB:`MODE_LSB] = mode_r;
		mode_rd[`FBCOMP_BIT] = fbcomp_r;
		if (mode_r == dpll_sel_pkg::MODE_AUTO) begin
			mode_rd[`REFSEL_MSB:`REFSEL_LSB] = {1'b0, sel_r};
		end else begin
			mode_rd[`REFSEL_MSB:`REFSEL_LSB] = refsel_r;
		end
		rdata_nxt = rdata_r;
		if (reg_rd) begin
			case (reg_addr)
				`MODE_SEL_ADDR: rdata_nxt = mode_rd;
				`FAIL_MASK_ADDR: rdata_nxt = mask_r;
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_r <= dpll_sel_pkg::op_mode_t'(MODE_RESET_VAL[`MODE_MSB:`MODE_LSB]);
			fbcomp_r <= MODE_RESET_VAL[`FBCOMP_BIT];
			refsel_r <= MODE_RESET_VAL[`REFSEL_MSB:`REFSEL_LSB];
			mask_r <= `FAIL_MASK_RESET;
			rdata_r <= 8'h00;
		end else begin
			mode_r <= mode_nxt;
			fbcomp_r <= fbcomp_nxt;
			refsel_r <= refsel_nxt;
			mask_r <= mask_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ==========================================================
	// Failure gating per reference, bit order loss, cycle, freq, guard
	logic [3:0] fails0;
	logic [3:0] fails1;
	logic [1:0] hold_fail;
	logic [1:0] switch_fail;

	always_comb begin
		fails0 = {guard_soak_timer[0], frequency_range_monitor[0],
			cycle_period_monitor[0], signal_loss_monitor[0]};
		fails1 = {guard_soak_timer[1], frequency_range_monitor[1],
			cycle_period_monitor[1], signal_loss_monitor[1]};
		hold_fail[0] = dpll_sel_pkg::masked_fail(fails0, mask_r[`HOLD_MSK_MSB:`HOLD_MSK_LSB]);
		hold_fail[1] = dpll_sel_pkg::masked_fail(fails1, mask_r[`HOLD_MSK_MSB:`HOLD_MSK_LSB]);
		switch_fail[0] = dpll_sel_pkg::masked_fail(fails0, mask_r[`SW_MSK_MSB:`SW_MSK_LSB]);
		switch_fail[1] = dpll_sel_pkg::masked_fail(fails1, mask_r[`SW_MSK_MSB:`SW_MSK_LSB]);
	end

	// ==========================================================
	// Mode and selection state
	dpll_sel_pkg::loop_state_t state_r, state_nxt;
	logic osc_r, osc_nxt;
	logic fbon_r;
	logic [PHASE_W-1:0] fbph_r, fbph_nxt;
	logic [1:0] usable;
	logic auto_sel;
	logic auto_hold;
	logic forced_ref;

	ref_chooser u_chooser (
		.sel_cur(sel_r),
		.rank0(reference_zero_rank),
		.rank1(reference_one_rank),
		.hold_fail(hold_fail),
		.switch_fail(switch_fail),
		.usable(usable),
		.sel_next(auto_sel),
		.hold_next(auto_hold)
	);

	// Codes 1x in the forced field are undefined; only the low bit counts
	assign forced_ref = refsel_r[0];

	always_comb begin
		sel_nxt = sel_r;
		state_nxt = state_r;
		osc_nxt = 1'b0;
		case (mode_r)
			dpll_sel_pkg::MODE_FREERUN: begin
				state_nxt = dpll_sel_pkg::ST_FREERUN;
				osc_nxt = 1'b1;
			end
			dpll_sel_pkg::MODE_HOLDOVER: begin
				// Last selection stays as the holdover basis
				state_nxt = dpll_sel_pkg::ST_HOLDOVER;
			end
			dpll_sel_pkg::MODE_FORCED: begin
				sel_nxt = forced_ref;
				state_nxt = hold_fail[forced_ref] ? dpll_sel_pkg::ST_HOLDOVER
					: dpll_sel_pkg::ST_LOCKED;
			end
			dpll_sel_pkg::MODE_AUTO: begin
				sel_nxt = auto_sel;
				state_nxt = auto_hold ? dpll_sel_pkg::ST_HOLDOVER
					: dpll_sel_pkg::ST_LOCKED;
			end
			default: begin
				state_nxt = dpll_sel_pkg::ST_FREERUN;
			end
		endcase
		// One shared feedback input, passed whichever loop made it
		fbph_nxt = fbcomp_r ? ext_feedback_phase : '0;
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			sel_r <= 1'b0;
			state_r <= dpll_sel_pkg::ST_FREERUN;
			osc_r <= 1'b0;
			fbon_r <= 1'b0;
			fbph_r <= '0;
		end else begin
			sel_r <= sel_nxt;
			state_r <= state_nxt;
			osc_r <= osc_nxt;
			fbon_r <= fbcomp_r;
			fbph_r <= fbph_nxt;
		end
	end

	// Ports straight from flip-flops
	assign reg_rdata = rdata_r;
	assign selected_ref = sel_r;
	assign pll_state = state_r;
	assign oscillator_only = osc_r;
	assign feedback_compensation_on = fbon_r;
	assign feedback_phase_comp = fbph_r;

	// ==========================================================
	// Checks
	a_freerun_osc_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_r == dpll_sel_pkg::MODE_FREERUN |=> state_r == dpll_sel_pkg::ST_FREERUN && osc_r)
		else $error("freerun mode not using oscillator only");

	a_holdover_keeps_sel: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_r == dpll_sel_pkg::MODE_HOLDOVER |=>
		state_r == dpll_sel_pkg::ST_HOLDOVER && sel_r == $past(sel_r))
		else $error("forced holdover changed selection or state");

	a_forced_no_switch: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_r == dpll_sel_pkg::MODE_FORCED && hold_fail[forced_ref] |=>
		state_r == dpll_sel_pkg::ST_HOLDOVER && sel_r == $past(forced_ref))
		else $error("forced reference failure did not hold on it");

	a_forced_sel_follows: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_r == dpll_sel_pkg::MODE_FORCED && !hold_fail[forced_ref] |=>
		sel_r == $past(refsel_r[0]) && state_r == dpll_sel_pkg::ST_LOCKED)
		else $error("forced reference not locked");

	a_auto_status_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		reg_rd && reg_addr == `MODE_SEL_ADDR && mode_r == dpll_sel_pkg::MODE_AUTO |=>
		rdata_r[`REFSEL_MSB:`REFSEL_LSB] == {1'b0, $past(sel_r)})
		else $error("automatic mode status field wrong");

	a_feedback_gate: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!fbcomp_r |=> fbph_r == '0 && !fbon_r)
		else $error("feedback phase used while compensation off");

	a_feedback_pass: assert property (@(posedge clk_sys) disable iff (sys_rst)
		fbcomp_r |=> fbph_r == $past(ext_feedback_phase))
		else $error("shared feedback phase not passed");

	a_auto_all_good: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_r == dpll_sel_pkg::MODE_AUTO && usable == 2'h3 |=>
		state_r == dpll_sel_pkg::ST_LOCKED)
		else $error("holdover entered with both references available");

	a_auto_revert: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_r == dpll_sel_pkg::MODE_AUTO && usable == 2'h3 &&
		reference_zero_rank != reference_one_rank |=>
		sel_r == ($past(reference_one_rank) < $past(reference_zero_rank)))
		else $error("better ranked reference not selected");

	a_masked_stays: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mode_r == dpll_sel_pkg::MODE_AUTO && !hold_fail[sel_r] && !switch_fail[sel_r] &&
		(sel_r ? reference_one_rank <= reference_zero_rank
		: reference_zero_rank <= reference_one_rank) &&
		(sel_r ? reference_one_rank : reference_zero_rank) != `RANK_DISABLED |=>
		sel_r == $past(sel_r) && state_r == dpll_sel_pkg::ST_LOCKED)
		else $error("masked failure moved the selection");

endmodule : dpll_mode_select
`default_nettype wire

// ==== bench/ref_monitor_model.sv ====
// Behavioural failure monitors of the two input references.
// Assumes the bench hands one failure nibble per reference.
`timescale 1ns/1ps
`default_nettype none

module ref_monitor_model (
	input wire logic clk_sys,
	input wire logic [3:0] fail0,
	input wire logic [3:0] fail1,
	output logic [1:0] signal_loss_monitor,
	output logic [1:0] cycle_period_monitor,
	output logic [1:0] frequency_range_monitor,
	output logic [1:0] guard_soak_timer
);
	// ==========================================================
	// Monitor flags
	// Nibble is {guard, freq, cycle, loss}; one cycle of monitor delay
	always @(posedge clk_sys) begin
		signal_loss_monitor <= {fail1[0], fail0[0]};
		cycle_period_monitor <= {fail1[1], fail0[1]};
		frequency_range_monitor <= {fail1[2], fail0[2]};
		guard_soak_timer <= {fail1[3], fail0[3]};
	end
endmodule : ref_monitor_model

`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench of the DPLL mode and reference selection block.
// Assumes the monitor model beside it and the plain byte register port.
`timescale 1ns/1ps
`default_nettype none
`include "dpll_sel_defines.svh"

module tb_top;
	logic clk_sys, sys_rst, reg_wr, reg_rd, selected_ref, oscillator_only, comp_on;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [3:0] fail0, fail1;
	logic [2:0] r0, r1;
	logic [1:0] pll_state, loss, cyc, frq, grd;
	logic [15:0] phase, phase_comp;
	int failures = 0;
	int total_checks = 0;

	ref_monitor_model ref_monitor_model_inst (.clk_sys(clk_sys), .fail0(fail0),
		.fail1(fail1), .signal_loss_monitor(loss), .cycle_period_monitor(cyc),
		.frequency_range_monitor(frq), .guard_soak_timer(grd));

	dpll_mode_select #(.PHASE_W(16)) dpll_mode_select_inst (.clk_sys(clk_sys),
		.sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .signal_loss_monitor(loss),
		.cycle_period_monitor(cyc), .frequency_range_monitor(frq), .guard_soak_timer(grd),
		.reference_zero_rank(r0), .reference_one_rank(r1), .ext_feedback_phase(phase),
		.selected_ref(selected_ref), .pll_state(pll_state),
		.oscillator_only(oscillator_only), .feedback_compensation_on(comp_on),
		.feedback_phase_comp(phase_comp));

	// ==========================================================
	// Clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	// Whole run is under two hundred cycles; the 5000-cycle limit is generous
	initial begin
		#100000;
		failures++;
		print_verdict();
	end

	// ==========================================================
	// Tasks
	task automatic print_verdict();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : print_verdict

	task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val

	task automatic check_out(input logic sel, input dpll_sel_pkg::loop_state_t st);
		total_checks++;
		if (selected_ref !== sel || pll_state !== st) begin
			failures++;
			$display("wrong value at %0t: sel %b state %b", $time, selected_ref, pll_state);
		end
	endtask : check_out

	// Strobe one cycle, released just after the edge that takes it
	task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys) #1;
		{reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge clk_sys) #1;
		reg_wr = 1'b0;
	endtask : reg_write

	task automatic check_reg(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk_sys) #1;
		{reg_rd, reg_addr} = {1'b1, a};
		@(posedge clk_sys) #1;
		reg_rd = 1'b0;
		check_val({8'h00, reg_rdata}, {8'h00, exp});
	endtask : check_reg

	// Monitor delay plus one edge of selection; two spare edges besides
	task automatic settle();
		repeat (4) @(posedge clk_sys);
		#1;
	endtask : settle

	// ==========================================================
	// Tests
	initial begin
		{reg_wr, reg_rd, reg_addr, reg_wdata, fail0, fail1} = '0;
		{r0, r1, phase, sys_rst} = {3'h0, 3'h1, 16'hA5C3, 1'b1};
		repeat (16) @(posedge clk_sys);
		#1 sys_rst = 1'b0;
		check_reg(`MODE_SEL_ADDR, 8'h03);
		check_reg(`FAIL_MASK_ADDR, 8'h87);
		check_reg(8'h35, 8'h00);
		settle();
		check_out(1'b0, dpll_sel_pkg::ST_LOCKED);
		$display("test reset done");
		// Each failure type: hold-only mask, then switch-only mask
		for (int i = 0; i < 4; i++) begin
			reg_write(`FAIL_MASK_ADDR, (8'h01 << i) | ((i == 3) ? 8'h06 : 8'h00));
			fail0 = 4'h1 << i;
			settle();
			check_out(1'b0, dpll_sel_pkg::ST_HOLDOVER);
			reg_write(`FAIL_MASK_ADDR, 8'h10 << i);
			settle();
			check_out(1'b1, dpll_sel_pkg::ST_LOCKED);
			fail0 = 4'h0;
			settle();
			check_out(1'b0, dpll_sel_pkg::ST_LOCKED);
		end
		$display("test masks done");
		reg_write(`FAIL_MASK_ADDR, 8'h11);
		{r1, fail0} = {3'h0, 4'h1};
		settle();
		fail0 = 4'h0;
		settle();
		check_out(1'b1, dpll_sel_pkg::ST_LOCKED);
		check_reg(`MODE_SEL_ADDR, 8'h43);
		fail1 = 4'h1;
		settle();
		check_out(1'b0, dpll_sel_pkg::ST_LOCKED);
		{r0, fail1} = {3'h7, 4'h0};
		settle();
		check_out(1'b1, dpll_sel_pkg::ST_LOCKED);
		fail1 = 4'h1;
		settle();
		check_out(1'b1, dpll_sel_pkg::ST_HOLDOVER);
		{r0, fail1} = {3'h0, 4'h0};
		$display("test auto done");
		reg_write(`MODE_SEL_ADDR, 8'h02);
		settle();
		check_out(1'b0, dpll_sel_pkg::ST_LOCKED);
		reg_write(`MODE_SEL_ADDR, 8'h42);
		settle();
		check_out(1'b1, dpll_sel_pkg::ST_LOCKED);
		fail1 = 4'h1;
		settle();
		check_out(1'b1, dpll_sel_pkg::ST_HOLDOVER);
		check_reg(`MODE_SEL_ADDR, 8'h42);
		$display("test forced done");
		reg_write(`MODE_SEL_ADDR, 8'h01);
		fail1 = 4'h0;
		settle();
		check_out(1'b1, dpll_sel_pkg::ST_HOLDOVER);
		reg_write(`MODE_SEL_ADDR, 8'h1D);
		settle();
		check_out(1'b1, dpll_sel_pkg::ST_HOLDOVER);
		check_reg(`MODE_SEL_ADDR, 8'h01);
		reg_write(`MODE_SEL_ADDR, 8'h00);
		settle();
		check_val({15'h0, oscillator_only}, 16'h0001);
		check_val({14'h0, pll_state}, 16'h0000);
		$display("test holdover freerun done");
		// Mid-run reset from freerun with ref1 held: outputs clear and registers return to reset values
		@(posedge clk_sys) #1 sys_rst = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check_val({15'h0, oscillator_only}, 16'h0000);
		check_out(1'b0, dpll_sel_pkg::ST_FREERUN);
		sys_rst = 1'b0;
		check_reg(`MODE_SEL_ADDR, 8'h03);
		check_reg(`FAIL_MASK_ADDR, 8'h87);
		$display("test mid-run reset done");
		reg_write(`MODE_SEL_ADDR, 8'h23);
		settle();
		check_val({15'h0, comp_on}, 16'h0001);
		check_val(phase_comp, 16'hA5C3);
		phase = 16'h5A3C;
		settle();
		check_val(phase_comp, 16'h5A3C);
		reg_write(`MODE_SEL_ADDR, 8'h03);
		settle();
		check_val({15'h0, comp_on}, 16'h0000);
		check_val(phase_comp, 16'h0000);
		$display("test compensation done");
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
